// >>> verilog/rtc_eeprom_serial_slave.sv
// two-wire serial slave front end with page buffer and programming cycle
//
// Contract
// - upper nibble selects array or clock/control space
// - device select bits must be all ones
// - last address bit: one reads, zero writes
// - acknowledge only matching slave address byte
// - two word address bytes; counter resets zero
// - byte write acked, stop starts programming
// - busy programming: ignore bus, release data
// - protected writes acked, never programmed
// - alarm registers commit only on multi-byte
// - page limits; timekeeping needs full page
// - write address wraps inside its page
// - extra page bytes overwrite in order
// - early or mid-byte stop aborts write
// - polling acked only after programming ends
// - current read sends byte after last read
// - random read: restart, read byte, data
// - stop after address sets counter, standby
// - sequential read increments, wraps whole space
// - no acknowledge on unmatched address byte
// - master nack stops further transmission
`timescale 1ns/1ps
`default_nettype none
module rtc_eeprom_serial_slave #(
	parameter int unsigned NV_CYCLES = rtc_serial_pkg::NV_WRITE_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic array_protect_i,
	output logic      sda_o,
	output logic      sda_oe_o,
	output logic      nv_busy_o
);
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} state_t;

	function automatic logic [15:0] page_inc(input logic [15:0] a,
	                                         input logic [15:0] m);
		page_inc = (a & ~m) | (16'(a + rtc_serial_pkg::ADDR_STEP) & m);
	endfunction

	function automatic logic in_range(input logic [15:0] a,
	                                  input logic [15:0] lo,
	                                  input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	logic                        scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
	logic                        scl_rise, scl_fall, start_ev, stop_ev;
	state_t                      st_reg, st_next;
	logic [3:0]                  cnt_reg, cnt_next;
	logic [7:0]                  shift_reg, shift_next;
	rtc_serial_pkg::byte_idx_t   idx_reg, idx_next;
	logic                        rd_reg, rd_next, space_reg, space_next;
	logic [15:0]                 addr_reg, addr_next, first_reg, first_next;
	logic [7:0]                  ahi_reg, ahi_next;
	logic [5:0]                  nb_reg, nb_next;
	logic                        prot_reg, prot_next, oe_reg, oe_next;
	logic                        mack_reg, mack_next, busy_reg, busy_next;
	logic [31:0]                 timer_reg, timer_next;
	logic                        wel_reg, wel_next, rwel_reg, rwel_next;
	logic                        sda_o_reg;
	logic                        addr_match, byte_done;
	logic                        f_in_valid, f_in_ready, f_clear;
	logic                        f_out_valid, f_out_ready;
	logic [rtc_serial_pkg::FIFO_W-1:0] f_in_data, f_out_data;
	logic [7:0]                  rdata;
	logic [15:0]                 lo_addr;

	// pins cross into the core clock through two flops before any use
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d  <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d  <= 1'b1;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_d  <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_d  <= sda_s2;
		end
	end

	assign scl_rise = scl_s2 & ~scl_d;
	assign scl_fall = ~scl_s2 & scl_d;
	assign start_ev = scl_s2 & scl_d & ~sda_s2 & sda_d;
	assign stop_ev  = scl_s2 & scl_d & sda_s2 & ~sda_d;

	assign addr_match = ((shift_reg[7:4] == rtc_serial_pkg::ID_ARRAY) ||
	                     (shift_reg[7:4] == rtc_serial_pkg::ID_CLOCK_CTRL)) &&
	                    (shift_reg[3:1] == rtc_serial_pkg::DEV_SELECT);
	assign byte_done  = (st_reg == ST_RX) && scl_fall &&
	                    (cnt_reg == rtc_serial_pkg::BITS_PER_BYTE);
	assign lo_addr    = {ahi_reg, shift_reg};
	assign f_in_data  = {space_reg, addr_reg, shift_reg};
	assign f_in_valid = byte_done && (idx_reg == rtc_serial_pkg::IDX_DATA) &&
	                    !prot_reg;

	// write commits are decided once, at the stop
	function automatic logic commit_ok(input logic sp, input logic [15:0] a,
	                                   input logic [5:0] n);
		commit_ok = 1'b1;
		if (sp && in_range(a, rtc_serial_pkg::ALARM_FIRST,
		                   rtc_serial_pkg::ALARM_LAST) &&
		    n < rtc_serial_pkg::ALARM_MIN_BYTES)
			commit_ok = 1'b0;
		if (sp && in_range(a, rtc_serial_pkg::RTC_FIRST,
		                   rtc_serial_pkg::RTC_LAST) &&
		    n < rtc_serial_pkg::RTC_PAGE_BYTES)
			commit_ok = 1'b0;
	endfunction

	always_comb begin
		st_next    = st_reg;
		cnt_next   = cnt_reg;
		shift_next = shift_reg;
		idx_next   = idx_reg;
		rd_next    = rd_reg;
		space_next = space_reg;
		addr_next  = addr_reg;
		first_next = first_reg;
		ahi_next   = ahi_reg;
		nb_next    = nb_reg;
		prot_next  = prot_reg;
		oe_next    = oe_reg;
		mack_next  = mack_reg;
		// bytes waiting in the buffer must not start a cycle before the stop
		busy_next  = busy_reg && ((timer_reg != '0) || f_out_valid);
		timer_next = (timer_reg != '0) ? timer_reg - 32'd1 : timer_reg;
		wel_next   = wel_reg;
		rwel_next  = rwel_reg;
		f_clear    = 1'b0;
		if (busy_reg) begin
			// bus ignored entirely while programming; polls go unanswered
			st_next = ST_IDLE;
			oe_next = 1'b0;
			if (f_out_valid && f_out_data[24] &&
			    f_out_data[23:8] == rtc_serial_pkg::STATUS_ADDR) begin
				wel_next  = (f_out_data[7:0] == rtc_serial_pkg::WEL_VALUE) ||
				            (f_out_data[7:0] == rtc_serial_pkg::RWEL_VALUE);
				rwel_next = wel_reg &&
				            (f_out_data[7:0] == rtc_serial_pkg::RWEL_VALUE);
			end
		end else if (stop_ev) begin
			st_next = ST_IDLE;
			oe_next = 1'b0;
			if (st_reg == ST_RX && !rd_reg &&
			    idx_reg == rtc_serial_pkg::IDX_DATA &&
			    cnt_reg == rtc_serial_pkg::STOP_BIT_CNT && nb_reg != '0 &&
			    !prot_reg && commit_ok(space_reg, first_reg, nb_reg)) begin
				busy_next  = 1'b1;
				timer_next = NV_CYCLES;
			end else begin
				// address-only stop keeps the loaded counter
				f_clear = 1'b1;
			end
		end else if (start_ev) begin
			// a restart drops any bytes loaded so far
			f_clear  = 1'b1;
			st_next  = ST_RX;
			cnt_next = '0;
			idx_next = rtc_serial_pkg::IDX_SLAVE;
			oe_next  = 1'b0;
		end else begin
			case (st_reg)
				ST_RX: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_s2};
						cnt_next   = 4'(cnt_reg + 1'b1);
					end else if (byte_done) begin
						st_next = ST_ACK;
						oe_next = 1'b1;
						case (idx_reg)
							rtc_serial_pkg::IDX_SLAVE: begin
								if (addr_match) begin
									rd_next    = shift_reg[0];
									space_next = shift_reg[7:4] ==
									             rtc_serial_pkg::ID_CLOCK_CTRL;
								end else begin
									st_next = ST_IDLE;
									oe_next = 1'b0;
								end
							end
							rtc_serial_pkg::IDX_ADDR_HI: ahi_next = shift_reg;
							rtc_serial_pkg::IDX_ADDR_LO: begin
								addr_next  = lo_addr;
								first_next = lo_addr;
								nb_next    = '0;
								prot_next  = space_reg ?
								             (lo_addr != rtc_serial_pkg::STATUS_ADDR &&
								              !(wel_reg && rwel_reg)) :
								             array_protect_i;
							end
							default: begin
								if (!prot_reg && !f_in_ready) begin
									// full buffer is refused rather than lost
									st_next = ST_IDLE;
									oe_next = 1'b0;
								end else begin
									addr_next = page_inc(addr_reg, space_reg ?
									            rtc_serial_pkg::CCR_PAGE_MASK :
									            rtc_serial_pkg::ARRAY_PAGE_MASK);
									if (nb_reg != rtc_serial_pkg::BYTES_MAX)
										nb_next = 6'(nb_reg + 1'b1);
								end
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						cnt_next = '0;
						if (rd_reg) begin
							st_next    = ST_TX;
							shift_next = rdata;
							oe_next    = ~rdata[7];
							addr_next  = 16'(addr_reg + rtc_serial_pkg::ADDR_STEP);
						end else begin
							st_next = ST_RX;
							oe_next = 1'b0;
							if (idx_reg != rtc_serial_pkg::IDX_DATA)
								idx_next = rtc_serial_pkg::byte_idx_t'(idx_reg + 2'd1);
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						cnt_next = 4'(cnt_reg + 1'b1);
					end else if (scl_fall) begin
						if (cnt_reg == rtc_serial_pkg::BITS_PER_BYTE) begin
							st_next = ST_RACK;
							oe_next = 1'b0;
						end else begin
							shift_next = {shift_reg[6:0], 1'b0};
							oe_next    = ~shift_reg[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						mack_next = ~sda_s2;
					end else if (scl_fall) begin
						cnt_next = '0;
						if (mack_reg) begin
							st_next    = ST_TX;
							shift_next = rdata;
							oe_next    = ~rdata[7];
							addr_next  = 16'(addr_reg + rtc_serial_pkg::ADDR_STEP);
						end else begin
							st_next = ST_IDLE;
						end
					end
				end
				default: begin
					st_next = ST_IDLE;
					oe_next = 1'b0;
				end
			endcase
		end
	end

	assign f_out_ready = busy_reg;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg    <= ST_IDLE;
			cnt_reg   <= '0;
			shift_reg <= '0;
			idx_reg   <= rtc_serial_pkg::IDX_SLAVE;
			rd_reg    <= 1'b0;
			space_reg <= 1'b0;
			addr_reg  <= rtc_serial_pkg::ADDR_RESET;
			first_reg <= rtc_serial_pkg::ADDR_RESET;
			ahi_reg   <= '0;
			nb_reg    <= '0;
			prot_reg  <= 1'b0;
			oe_reg    <= 1'b0;
			mack_reg  <= 1'b0;
			busy_reg  <= 1'b0;
			timer_reg <= '0;
			wel_reg   <= 1'b0;
			rwel_reg  <= 1'b0;
			sda_o_reg <= 1'b0;
		end else begin
			st_reg    <= st_next;
			cnt_reg   <= cnt_next;
			shift_reg <= shift_next;
			idx_reg   <= idx_next;
			rd_reg    <= rd_next;
			space_reg <= space_next;
			addr_reg  <= addr_next;
			first_reg <= first_next;
			ahi_reg   <= ahi_next;
			nb_reg    <= nb_next;
			prot_reg  <= prot_next;
			oe_reg    <= oe_next;
			mack_reg  <= mack_next;
			busy_reg  <= busy_next;
			timer_reg <= timer_next;
			wel_reg   <= wel_next;
			rwel_reg  <= rwel_next;
			sda_o_reg <= 1'b0;
		end
	end

	assign sda_o     = sda_o_reg;
	assign sda_oe_o  = oe_reg;
	assign nv_busy_o = busy_reg;

	page_fifo #(
		.WIDTH(rtc_serial_pkg::FIFO_W),
		.DEPTH(rtc_serial_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.clear_i    (f_clear),
		.in_valid_i (f_in_valid),
		.in_ready_o (f_in_ready),
		.in_data_i  (f_in_data),
		.out_valid_o(f_out_valid),
		.out_ready_i(f_out_ready),
		.out_data_o (f_out_data)
	);

	nv_store u_store (
		.clk_i   (clk_i),
		.we_i    (f_out_valid & busy_reg),
		.wspace_i(f_out_data[24]),
		.waddr_i (f_out_data[23:8]),
		.wdata_i (f_out_data[7:0]),
		.rspace_i(space_reg),
		.raddr_i (addr_reg),
		.rdata_o (rdata)
	);

	a_busy_released: assert property (@(posedge clk_i) disable iff (rst_i)
		busy_reg |=> !oe_reg) else $error("data driven while busy");
	a_addr_nack: assert property (@(posedge clk_i) disable iff (rst_i)
		byte_done && idx_reg == rtc_serial_pkg::IDX_SLAVE && !addr_match
		|=> !oe_reg && st_reg == ST_IDLE)
		else $error("unmatched address acknowledged");
	a_addr_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		byte_done && idx_reg == rtc_serial_pkg::IDX_SLAVE && addr_match
		&& !start_ev && !stop_ev |=> oe_reg && st_reg == ST_ACK)
		else $error("matched address not acknowledged");
	a_dir_bit: assert property (@(posedge clk_i) disable iff (rst_i)
		byte_done && idx_reg == rtc_serial_pkg::IDX_SLAVE && addr_match
		&& !start_ev && !stop_ev |=> rd_reg == $past(shift_reg[0]))
		else $error("direction bit not taken");
	a_page_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
		f_in_valid && f_in_ready && !start_ev && !stop_ev && !space_reg
		|=> addr_reg[15:4] == $past(addr_reg[15:4]))
		else $error("write address left its page");
	a_read_step: assert property (@(posedge clk_i) disable iff (rst_i)
		st_reg == ST_RACK && scl_fall && mack_reg && !busy_reg
		&& !start_ev && !stop_ev
		|=> addr_reg == 16'($past(addr_reg) + rtc_serial_pkg::ADDR_STEP))
		else $error("read address did not advance");
	a_nack_ends: assert property (@(posedge clk_i) disable iff (rst_i)
		st_reg == ST_RACK && scl_fall && !mack_reg
		|=> st_reg == ST_IDLE ##1 !oe_reg)
		else $error("transmit continued after nack");
	a_prot_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		byte_done && idx_reg == rtc_serial_pkg::IDX_DATA && prot_reg
		|-> !f_in_valid ##1 oe_reg)
		else $error("protected byte buffered or not acked");
	a_abort_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_ev && !busy_reg && cnt_reg != rtc_serial_pkg::STOP_BIT_CNT
		|=> !busy_reg) else $error("aborted write programmed");
endmodule
`default_nettype wire

// >>> include/rtc_serial_pkg.sv
// constants shared by the two-wire serial slave, its page buffer and its store
package rtc_serial_pkg;
	localparam int           CLK_PERIOD_NS   = 4;
	localparam int           NV_WRITE_NS     = 5000000;
	localparam int           NV_WRITE_CYCLES = NV_WRITE_NS / CLK_PERIOD_NS;
	localparam logic [3:0]   ID_ARRAY        = 4'hA;
	localparam logic [3:0]   ID_CLOCK_CTRL   = 4'hD;
	localparam logic [2:0]   DEV_SELECT      = 3'h7;
	localparam logic [15:0]  ARRAY_PAGE_MASK = 16'h000F;
	localparam logic [15:0]  CCR_PAGE_MASK   = 16'h0007;
	localparam logic [15:0]  ADDR_STEP       = 16'h0001;
	localparam logic [15:0]  ADDR_RESET      = 16'h0000;
	localparam int           ARRAY_AW        = 9;
	localparam int           CCR_AW          = 6;
	localparam logic [15:0]  STATUS_ADDR     = 16'h003F;
	localparam logic [7:0]   WEL_VALUE       = 8'h02;
	localparam logic [7:0]   RWEL_VALUE      = 8'h06;
	localparam logic [15:0]  ALARM_FIRST     = 16'h0000;
	localparam logic [15:0]  ALARM_LAST      = 16'h000F;
	localparam logic [15:0]  RTC_FIRST       = 16'h0030;
	localparam logic [15:0]  RTC_LAST        = 16'h0037;
	localparam logic [5:0]   ALARM_MIN_BYTES = 6'h02;
	localparam logic [5:0]   RTC_PAGE_BYTES  = 6'h08;
	localparam logic [5:0]   BYTES_MAX       = 6'h3F;
	localparam logic [3:0]   BITS_PER_BYTE   = 4'h8;
	localparam logic [3:0]   STOP_BIT_CNT    = 4'h1;
	localparam int           FIFO_W          = 25;
	localparam int           FIFO_DEPTH      = 32;
	typedef enum logic [1:0] {
		IDX_SLAVE,
		IDX_ADDR_HI,
		IDX_ADDR_LO,
		IDX_DATA
	} byte_idx_t;
endpackage

// >>> verilog/page_fifo.sv
// first-in first-out buffer for page write bytes awaiting programming
`timescale 1ns/1ps
`default_nettype none
module page_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             clear_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;

	assign in_ready_o  = (cnt_reg != FULL_CNT);
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o  = mem[rptr_reg];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_comb begin
		wptr_next = wptr_reg;
		rptr_next = rptr_reg;
		cnt_next  = cnt_reg;
		if (clear_i) begin
			wptr_next = '0;
			rptr_next = '0;
			cnt_next  = '0;
		end else begin
			if (push)
				wptr_next = AW'(wptr_reg + 1'b1);
			if (pop)
				rptr_next = AW'(rptr_reg + 1'b1);
			if (push && !pop)
				cnt_next = (AW+1)'(cnt_reg + 1'b1);
			else if (pop && !push)
				cnt_next = (AW+1)'(cnt_reg - 1'b1);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg  <= '0;
		end else begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			cnt_reg  <= cnt_next;
		end
	end

	// storage carries no reset; stale words are unreachable behind the count
	always_ff @(posedge clk_i) begin
		if (push && !clear_i)
			mem[wptr_reg] <= in_data_i;
	end
endmodule
`default_nettype wire

// >>> verilog/nv_store.sv
// nonvolatile byte store: memory array and clock/control space
`timescale 1ns/1ps
`default_nettype none
module nv_store (
	input  wire logic        clk_i,
	input  wire logic        we_i,
	input  wire logic        wspace_i,
	input  wire logic [15:0] waddr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        rspace_i,
	input  wire logic [15:0] raddr_i,
	output logic      [7:0]  rdata_o
);
	localparam int ARRAY_DEPTH = 1 << rtc_serial_pkg::ARRAY_AW;
	localparam int CCR_DEPTH   = 1 << rtc_serial_pkg::CCR_AW;

	logic [7:0] array_mem [ARRAY_DEPTH];
	logic [7:0] ccr_mem   [CCR_DEPTH];

	// addresses above each space alias onto it
	assign rdata_o = rspace_i ? ccr_mem[raddr_i[rtc_serial_pkg::CCR_AW-1:0]]
	                          : array_mem[raddr_i[rtc_serial_pkg::ARRAY_AW-1:0]];

	always_ff @(posedge clk_i) begin
		if (we_i && wspace_i)
			ccr_mem[waddr_i[rtc_serial_pkg::CCR_AW-1:0]] <= wdata_i;
		if (we_i && !wspace_i)
			array_mem[waddr_i[rtc_serial_pkg::ARRAY_AW-1:0]] <= wdata_i;
	end
endmodule
`default_nettype wire

// >>> verification/i2c_master_model.sv
// two-wire bus master model that drives the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	// scl stands high between frames; a released sda reads as the pull-up
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// waits out an ack still held low before raising scl
	task automatic start_cond();
		sda_o <= 1'b1;
		tick(4);
		scl_o <= 1'b1;
		tick(4);
		sda_o <= 1'b0;
		tick(4);
		scl_o <= 1'b0;
		tick(2);
	endtask
	task automatic stop_cond();
		sda_o <= 1'b0;
		tick(4);
		scl_o <= 1'b1;
		tick(4);
		sda_o <= 1'b1;
		tick(4);
	endtask
	// data moves only while scl is low, sampled mid high phase
	task automatic put_bit(input logic b, output logic s);
		sda_o <= b;
		tick(2);
		scl_o <= 1'b1;
		tick(2);
		s = sda_i;
		tick(2);
		scl_o <= 1'b0;
		tick(2);
	endtask
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i], s);
		put_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic read_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, s);
			d[i] = s;
		end
		put_bit(~ack, s);
	endtask
endmodule
`default_nettype wire

// >>> verification/rtc_eeprom_serial_slave_tb.sv
// self-checking bench for the two-wire serial slave
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin \
	cmp_count++; \
	if ((a) !== (b)) begin \
		num_errors++; \
		$display("unexpected at %0t got %h want %h", $time, (a), (b)); \
	end \
end
module rtc_eeprom_serial_slave_tb;
	localparam int NV = 200;
	// busy is seen from the edge after the stop through the count, inclusive
	localparam int NV_SPAN = NV + 1;
	logic       clk_i           = 1'b0;
	logic       rst_i           = 1'b1;
	logic       array_protect_i = 1'b0;
	logic       m_scl;
	logic       m_sda;
	logic       sda_o;
	logic       sda_oe_o;
	logic       nv_busy_o;
	wire        sda_line;
	int         num_errors      = 0;
	int         cmp_count       = 0;
	int         seed            = 96481;
	int         n;
	logic       ack;
	logic [7:0] d;
	logic [15:0] pa;
	logic [7:0] slv [6] = '{8'hAC, 8'hA2, 8'h5E, 8'hDA, 8'hDE, 8'h00};
	logic [7:0] exp_mem [0:511];
	always #2 clk_i = ~clk_i;
	assign sda_line = (sda_oe_o ? sda_o : 1'b1) & m_sda;
	rtc_eeprom_serial_slave #(.NV_CYCLES(NV)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .scl_i(m_scl), .sda_i(sda_line),
		.array_protect_i(array_protect_i), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .nv_busy_o(nv_busy_o));
	i2c_master_model master_u (
		.clk_i(clk_i), .sda_i(sda_line), .scl_o(m_scl), .sda_o(m_sda));
	function automatic logic addr_ok(input logic [7:0] b);
		return (b[7:4] === rtc_serial_pkg::ID_ARRAY
			|| b[7:4] === rtc_serial_pkg::ID_CLOCK_CTRL)
			&& b[3:1] === rtc_serial_pkg::DEV_SELECT;
	endfunction
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic send(input logic [7:0] b, input logic exp);
		master_u.write_byte(b, ack);
		`CHECK(ack, exp)
	endtask
	task automatic header(input logic [15:0] a);
		master_u.start_cond();
		send(8'hAE, 1'b1);
		send(a[15:8], 1'b1);
		send(a[7:0], 1'b1);
	endtask
	task automatic busy_len(output int c);
		c = 0;
		while (nv_busy_o === 1'b1 && c < 4 * NV) begin
			@(posedge clk_i);
			c++;
		end
	endtask
	task automatic page_write(input logic [15:0] a, input int cnt);
		logic [15:0] w;
		header(a);
		for (int i = 0; i < cnt; i++) begin
			w = {a[15:4], 4'(a[3:0] + i)};
			d = 8'($random(seed));
			exp_mem[w[8:0]] = d;
			send(d, 1'b1);
		end
		master_u.stop_cond();
	endtask
	task automatic ccr_write(input logic [15:0] a, input logic [7:0] v);
		master_u.start_cond();
		send(8'hDE, 1'b1);
		send(a[15:8], 1'b1);
		send(a[7:0], 1'b1);
		send(v, 1'b1);
		master_u.stop_cond();
		busy_len(n);
	endtask
	task automatic read_run(input logic [15:0] a, input int cnt);
		logic [15:0] r;
		for (int i = 0; i < cnt; i++) begin
			r = a + 16'(i);
			master_u.read_byte(i < cnt - 1, d);
			`CHECK(d, exp_mem[r[8:0]])
		end
		master_u.stop_cond();
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		`CHECK(sda_oe_o, 1'b0)
		`CHECK(nv_busy_o, 1'b0)
		page_write(16'h0000, 1);
		busy_len(n);
		`CHECK(n, NV_SPAN)
		page_write(16'h01FF, 1);
		busy_len(n);
		// eighteen bytes into a sixteen byte page wrap over the first two
		pa = {7'h00, 5'($random(seed)), 4'hA};
		page_write(pa, 18);
		master_u.start_cond();
		send(8'hAF, 1'b0);
		master_u.stop_cond();
		busy_len(n);
		`CHECK(n > 0, 1'b1)
		master_u.start_cond();
		send(8'hAE, 1'b1);
		master_u.stop_cond();
		header({pa[15:4], 4'h0});
		master_u.start_cond();
		send(8'hAF, 1'b1);
		read_run({pa[15:4], 4'h0}, 16);
		busy_len(n);
		`CHECK(n, 0)
		header(16'hFFFF);
		master_u.stop_cond();
		busy_len(n);
		`CHECK(n, 0)
		master_u.start_cond();
		send(8'hAF, 1'b1);
		read_run(16'hFFFF, 2);
		slv[5] = 8'($random(seed)) & 8'hFE;
		for (int i = 0; i < 6; i++) begin
			master_u.start_cond();
			send(slv[i], addr_ok(slv[i]));
			master_u.stop_cond();
		end
		busy_len(n);
		`CHECK(n, 0)
		// protected array: acked, not programmed
		array_protect_i <= 1'b1;
		header(16'h0000);
		send(~exp_mem[0], 1'b1);
		master_u.stop_cond();
		busy_len(n);
		`CHECK(n, 0)
		array_protect_i <= 1'b0;
		header(16'h0000);
		for (int i = 0; i < 4; i++)
			master_u.put_bit(~exp_mem[0][7 - i], ack);
		master_u.stop_cond();
		busy_len(n);
		`CHECK(n, 0)
		// clock space stays closed until 02h then 06h reach the status byte
		ccr_write(16'h0010, 8'h3C);
		`CHECK(n, 0)
		ccr_write(rtc_serial_pkg::STATUS_ADDR, rtc_serial_pkg::WEL_VALUE);
		`CHECK(n, NV_SPAN)
		ccr_write(rtc_serial_pkg::STATUS_ADDR, rtc_serial_pkg::RWEL_VALUE);
		`CHECK(n, NV_SPAN)
		ccr_write(16'h0000, 8'h11);
		`CHECK(n, 0)
		ccr_write(16'h0030, 8'h22);
		`CHECK(n, 0)
		ccr_write(16'h0010, 8'h5A);
		`CHECK(n, NV_SPAN)
		master_u.start_cond();
		send(8'hDE, 1'b1);
		send(8'h00, 1'b1);
		send(8'h10, 1'b1);
		master_u.start_cond();
		send(8'hDF, 1'b1);
		master_u.read_byte(1'b0, d);
		`CHECK(d, 8'h5A)
		master_u.stop_cond();
		// a second reset clears the counter but keeps the stored bytes
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		master_u.start_cond();
		send(8'hAF, 1'b1);
		read_run(16'h0000, 1);
		end_of_test();
	end
	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
